// ---- hw/ssic_defines.svh ----
// Register map, field positions, reset values and timing constants
`ifndef SSIC_DEFINES_SVH
`define SSIC_DEFINES_SVH
`define SSIC_ADDR_W        32
`define SSIC_DATA_W        32
`define SSIC_PRESCALE_ADDR 32'h40040010
`define SSIC_MASK_ADDR     32'h40040014
`define SSIC_RAW_ADDR      32'h40040018
`define SSIC_MASKED_ADDR   32'h4004001C
`define SSIC_CLEAR_ADDR    32'h40040020
`define SSIC_RATE_ADDR     32'h40040024
`define SSIC_BIT_OVERRUN   0
`define SSIC_BIT_TIMEOUT   1
`define SSIC_BIT_RX_HALF   2
`define SSIC_BIT_TX_HALF   3
`define SSIC_NUM_IRQ       4
`define SSIC_RAW_RESET     4'h8
`define SSIC_MASK_RESET    4'h0
`define SSIC_PRESCALE_RST  8'h00
`define SSIC_RATE_RST      8'h00
`define SSIC_PRESCALE_MIN  8'h02
`define SSIC_FIFO_DEPTH    4'h8
`define SSIC_FIFO_HALF     4'h4
`define SSIC_CNT_W         4
`define SSIC_TIMEOUT_BITS  6'h20
`define SSIC_BITS_W        6
`define SSIC_PERIOD_W      16
`endif

// ---- hw/ssic_pkg.sv ----
// Types shared by the serial port interrupt status and clear block
package ssic_pkg;
    typedef struct packed {
        logic tx_half_empty;
        logic rx_half_full;
        logic rx_timeout;
        logic overrun;
    } ssic_irq_type;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } ssic_apb_req_type;
endpackage

// ---- hw/ssic_top.sv ----
// Interrupt status, mask and clear logic of a synchronous serial port
//
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`include "ssic_defines.svh"

module ssic_top
    import ssic_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  rx_count,
    input  wire logic [3:0]  tx_count,
    input  wire logic        rx_frame_done,
    input  wire logic        rx_fifo_read,
    output logic             rx_overwrite,
    output logic             ssp_irq
);

    // Bit period in pclk cycles; odd or too small divisors are coerced
    function automatic logic [`SSIC_PERIOD_W-1:0] ssic_bit_period(
        input logic [7:0] pre,
        input logic [7:0] rate
    );
        logic [7:0] even_pre;
        even_pre = {pre[7:1], 1'b0};
        if (even_pre < `SSIC_PRESCALE_MIN) begin
            even_pre = `SSIC_PRESCALE_MIN;
        end
        ssic_bit_period = even_pre * ({8'h00, rate} + 16'h0001);
    endfunction

    function automatic logic [31:0] ssic_zext(input ssic_irq_type v);
        ssic_zext = {28'h0000000, v};
    endfunction

    ssic_apb_req_type req;
    ssic_irq_type     raw_r;
    ssic_irq_type     raw_nxt;
    ssic_irq_type     mask_r;
    ssic_irq_type     mask_nxt;
    ssic_irq_type     masked;
    logic [7:0]       prescale_r;
    logic [7:0]       rate_r;
    logic [31:0]      prdata_r;
    logic [31:0]      rdata_nxt;
    logic             pready_r;
    logic             pslverr_r;
    logic             irq_r;
    logic             overwrite_r;
    logic [`SSIC_PERIOD_W-1:0] cycle_cnt_r;
    logic [`SSIC_PERIOD_W-1:0] cycle_cnt_nxt;
    logic [`SSIC_BITS_W-1:0]   bits_cnt_r;
    logic [`SSIC_BITS_W-1:0]   bits_cnt_nxt;

    // Bus decode
    wire setup_phase = req.sel & ~req.enable;
    wire access_done = req.sel & req.enable & pready_r;
    wire wr_done     = access_done & req.write;
    wire hit_pre     = req.addr == `SSIC_PRESCALE_ADDR;
    wire hit_mask    = req.addr == `SSIC_MASK_ADDR;
    wire hit_raw     = req.addr == `SSIC_RAW_ADDR;
    wire hit_masked  = req.addr == `SSIC_MASKED_ADDR;
    wire hit_clear   = req.addr == `SSIC_CLEAR_ADDR;
    wire hit_rate    = req.addr == `SSIC_RATE_ADDR;
    wire hit_any     = hit_pre | hit_mask | hit_raw | hit_masked |
                       hit_clear | hit_rate;
    wire wr_pre      = wr_done & hit_pre;
    wire wr_mask     = wr_done & hit_mask;
    wire wr_rate     = wr_done & hit_rate;
    wire wr_clear    = wr_done & hit_clear;
    wire clr_overrun = wr_clear & pwdata[`SSIC_BIT_OVERRUN];
    wire clr_timeout = wr_clear & pwdata[`SSIC_BIT_TIMEOUT];

    // Next mask feeds the interrupt flop so it never lags a mask write
    assign mask_nxt = wr_mask ? ssic_irq_type'(req.wdata[`SSIC_NUM_IRQ-1:0])
                              : mask_r;

    assign req = '{sel: psel, enable: penable, write: pwrite,
                   addr: paddr, wdata: pwdata};

    // Receive and transmit status from the FIFO levels
    wire rx_empty    = rx_count == 4'h0;
    wire rx_full     = rx_count >= `SSIC_FIFO_DEPTH;
    wire rx_half     = rx_count >= `SSIC_FIFO_HALF;
    wire tx_half     = (`SSIC_FIFO_DEPTH - tx_count) >= `SSIC_FIFO_HALF;
    wire overrun_evt = rx_frame_done & rx_full;

    // Timeout counter, independent of master or slave operation
    wire [`SSIC_PERIOD_W-1:0] bit_period = ssic_bit_period(prescale_r,
                                                           rate_r);
    wire bit_tick    = cycle_cnt_r >= (bit_period - 16'h0001);
    wire idle_reset  = rx_empty | rx_fifo_read;
    wire bits_full   = bits_cnt_r >= `SSIC_TIMEOUT_BITS;
    wire timeout_evt = ~idle_reset & bits_full;

    always_comb begin
        cycle_cnt_nxt = cycle_cnt_r + 16'h0001;
        bits_cnt_nxt  = bits_cnt_r;
        if (idle_reset) begin
            cycle_cnt_nxt = '0;
            bits_cnt_nxt  = '0;
        end else if (bits_full) begin
            cycle_cnt_nxt = '0;
        end else if (bit_tick) begin
            cycle_cnt_nxt = '0;
            bits_cnt_nxt  = bits_cnt_r + 6'h01;
        end
    end

    // Raw status: sticky events, set wins over clear; live levels
    always_comb begin
        raw_nxt               = raw_r;
        raw_nxt.overrun       = overrun_evt |
                                (raw_r.overrun & ~clr_overrun);
        raw_nxt.rx_timeout    = timeout_evt |
                                (raw_r.rx_timeout & ~clr_timeout);
        raw_nxt.rx_half_full  = rx_half;
        raw_nxt.tx_half_empty = tx_half;
    end

    assign masked = raw_r & mask_r;

    // Read data; clear register reads zero, status writes are dropped
    assign rdata_nxt = hit_pre    ? {24'h000000, prescale_r[7:1], 1'b0} :
                       hit_mask   ? ssic_zext(mask_r) :
                       hit_raw    ? ssic_zext(raw_r) :
                       hit_masked ? ssic_zext(masked) :
                       hit_rate   ? {24'h000000, rate_r} :
                       32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_r <= `SSIC_RAW_RESET;
        end else begin
            raw_r <= raw_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r     <= `SSIC_MASK_RESET;
            prescale_r <= `SSIC_PRESCALE_RST;
            rate_r     <= `SSIC_RATE_RST;
        end else begin
            mask_r <= mask_nxt;
            if (wr_pre) begin
                prescale_r <= {req.wdata[7:1], 1'b0};
            end
            if (wr_rate) begin
                rate_r <= req.wdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_cnt_r <= '0;
            bits_cnt_r  <= '0;
        end else begin
            cycle_cnt_r <= cycle_cnt_nxt;
            bits_cnt_r  <= bits_cnt_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= setup_phase;
            pslverr_r <= setup_phase & ~hit_any;
            if (setup_phase) begin
                prdata_r <= req.write ? 32'h00000000 : rdata_nxt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r       <= 1'b0;
            overwrite_r <= 1'b0;
        end else begin
            irq_r       <= |(raw_nxt & mask_nxt);
            overwrite_r <= overrun_evt;
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign ssp_irq      = irq_r;
    assign rx_overwrite = overwrite_r;

    // Checks
    default clocking ck @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence full_frame_s;
        rx_frame_done && rx_count >= `SSIC_FIFO_DEPTH;
    endsequence

    sequence clear_ov_s;
        psel && penable && pready && pwrite &&
        paddr == `SSIC_CLEAR_ADDR && pwdata[`SSIC_BIT_OVERRUN];
    endsequence

    sequence clear_to_s;
        psel && penable && pready && pwrite &&
        paddr == `SSIC_CLEAR_ADDR && pwdata[`SSIC_BIT_TIMEOUT];
    endsequence

    overrun_set_a: assert property (
        full_frame_s |=> raw_r.overrun && rx_overwrite)
        else $error("overrun not flagged on full-FIFO frame");

    overrun_clear_a: assert property (
        clear_ov_s and !(rx_frame_done &&
        rx_count >= `SSIC_FIFO_DEPTH) |=> !raw_r.overrun)
        else $error("overrun not cleared by clear write");

    timeout_clear_a: assert property (
        clear_to_s and !(rx_count != 4'h0 && !rx_fifo_read &&
        bits_cnt_r >= `SSIC_TIMEOUT_BITS) |=> !raw_r.rx_timeout)
        else $error("timeout not cleared by clear write");

    zero_clear_a: assert property (
        psel && penable && pready && pwrite &&
        paddr == `SSIC_CLEAR_ADDR && !pwdata[0] && raw_r.overrun
        |=> raw_r.overrun)
        else $error("zero clear bit dropped overrun");

    timeout_set_a: assert property (
        rx_count != 4'h0 && !rx_fifo_read &&
        bits_cnt_r >= `SSIC_TIMEOUT_BITS |=> raw_r.rx_timeout)
        else $error("timeout not flagged after 32 bit times");

    timeout_early_a: assert property (
        $rose(raw_r.rx_timeout) |-> $past(bits_cnt_r) >= `SSIC_TIMEOUT_BITS)
        else $error("timeout flagged before 32 bit times");

    rx_level_a: assert property (
        ##1 raw_r.rx_half_full == ($past(rx_count) >= `SSIC_FIFO_HALF))
        else $error("receive level flag wrong");

    tx_level_a: assert property (
        ##1 raw_r.tx_half_empty ==
        ($past(tx_count) <= (`SSIC_FIFO_DEPTH - `SSIC_FIFO_HALF)))
        else $error("transmit level flag wrong");

    masked_read_a: assert property (
        psel && !penable && !pwrite && paddr == `SSIC_MASKED_ADDR
        |=> prdata[3:0] == $past(raw_r & mask_r) && prdata[31:4] == 0)
        else $error("masked status read mismatch");

    raw_read_a: assert property (
        psel && !penable && !pwrite && paddr == `SSIC_RAW_ADDR
        |=> prdata[3:0] == $past(raw_r))
        else $error("raw status read mismatch");

    irq_level_a: assert property (
        ssp_irq == |(raw_r & mask_r))
        else $error("interrupt output disagrees with masked status");

    apb_answer_a: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");

    sequence mask_wr_s;
        psel && penable && pready && pwrite &&
        paddr == `SSIC_MASK_ADDR;
    endsequence

    mask_write_a: assert property (
        mask_wr_s |=> mask_r == $past(pwdata[`SSIC_NUM_IRQ-1:0]))
        else $error("enable mask not written");

    overwrite_pulse_a: assert property (
        ##1 rx_overwrite ==
        $past(rx_frame_done && rx_count >= `SSIC_FIFO_DEPTH))
        else $error("overwrite pulse wrong");

    overrun_spurious_a: assert property (
        !raw_r.overrun && !(rx_frame_done &&
        rx_count >= `SSIC_FIFO_DEPTH) |=> !raw_r.overrun)
        else $error("overrun set without a full-FIFO frame");

    overrun_hold_a: assert property (
        raw_r.overrun && !(psel && penable && pready && pwrite &&
        paddr == `SSIC_CLEAR_ADDR && pwdata[`SSIC_BIT_OVERRUN])
        |=> raw_r.overrun)
        else $error("overrun dropped without a clear");

    timeout_spurious_a: assert property (
        !raw_r.rx_timeout && !(rx_count != '0 && !rx_fifo_read &&
        bits_cnt_r >= `SSIC_TIMEOUT_BITS) |=> !raw_r.rx_timeout)
        else $error("timeout set without an idle FIFO");

    timeout_hold_a: assert property (
        raw_r.rx_timeout && !(psel && penable && pready && pwrite &&
        paddr == `SSIC_CLEAR_ADDR && pwdata[`SSIC_BIT_TIMEOUT])
        |=> raw_r.rx_timeout)
        else $error("timeout dropped without a clear");

    bits_bound_a: assert property (
        bits_cnt_r <= `SSIC_TIMEOUT_BITS)
        else $error("bit counter ran past the timeout");

    prescale_even_a: assert property (
        prescale_r[0] == 1'b0)
        else $error("prescale divisor odd");

    write_zero_a: assert property (
        psel && !penable && pwrite |=> prdata == '0)
        else $error("read data not zero on a write");

    clear_read_a: assert property (
        psel && !penable && !pwrite && paddr == `SSIC_CLEAR_ADDR
        |=> prdata == '0)
        else $error("clear register read not zero");

    ready_setup_a: assert property (
        pready |-> $past(psel && !penable))
        else $error("bus answer without a setup cycle");

    error_ready_a: assert property (
        pslverr |-> pready)
        else $error("bus error outside the access phase");

endmodule // ssic_top

// ---- sim/test_ssic_top.sv ----
// Self-checking bench of the serial port interrupt status and clear block
`timescale 1ns/1ns
`include "ssic_defines.svh"

module test_ssic_top
    import ssic_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic [31:0] paddr, pwdata, prdata, rd, seed;
    logic        pready, pslverr, rx_overwrite, ssp_irq;
    logic [3:0]  rx_count, tx_count, mask_m;
    logic        rx_frame_done, rx_fifo_read;
    int          checks, bad_count, cyc;

    ssic_top ssic_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_count(rx_count), .tx_count(tx_count),
        .rx_frame_done(rx_frame_done), .rx_fifo_read(rx_fifo_read),
        .rx_overwrite(rx_overwrite), .ssp_irq(ssp_irq));

    always #5 pclk = ~pclk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected raw status from the FIFO levels and the sticky events
    function automatic logic [3:0] raw_exp(input logic ov, input logic to);
        ssic_irq_type r;
        r.overrun       = ov;
        r.rx_timeout    = to;
        r.rx_half_full  = rx_count >= 4'h4;
        r.tx_half_empty = tx_count <= 4'h4;
        return r;
    endfunction

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; read data and error kept in rd and err
    task automatic apb(input logic wr, input logic [31:0] a, d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Only the four defined bits are compared; upper bits read zero
    task automatic rd_chk(input logic [31:0] a, input logic [3:0] exp);
        apb(1'b0, a, 32'h0);
        check({28'h0, rd[3:0]}, {28'h0, exp});
    endtask

    task automatic irq_chk(input logic [3:0] raw);
        @(posedge pclk);
        check({31'h0, ssp_irq}, {31'h0, |(raw & mask_m)});
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            bad_count++;
            $display("Error at %0t: run did not finish", $time);
            end_sim();
        end
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; rx_count = 0; tx_count = 0; mask_m = 0;
        rx_frame_done = 0; rx_fifo_read = 1; seed = 32'hCB16B075; cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`SSIC_RAW_ADDR, 4'h8);
        rd_chk(`SSIC_MASKED_ADDR, 4'h0);
        $display("Test reset values done");
        // Random levels and masks; reads keep the timeout counter idle
        for (int i = 0; i < 24; i++) begin
            mask_m = 4'(xs());
            apb(1'b1, `SSIC_MASK_ADDR, {28'h0, mask_m});
            rx_count <= 4'(xs() % 9);
            tx_count <= 4'(xs() % 9);
            repeat (2) @(posedge pclk);
            rd_chk(`SSIC_RAW_ADDR, raw_exp(0, 0));
            rd_chk(`SSIC_MASKED_ADDR, raw_exp(0, 0) & mask_m);
            rd_chk(`SSIC_MASK_ADDR, mask_m);
            irq_chk(raw_exp(0, 0));
        end
        $display("Test levels and mask done");
        mask_m = 4'h1;
        apb(1'b1, `SSIC_MASK_ADDR, 32'h1);
        for (int c = 7; c <= 8; c++) begin
            rx_count      <= 4'(c);
            @(posedge pclk);
            rx_frame_done <= 1'b1;
            rx_fifo_read  <= 1'b0;
            @(posedge pclk);
            rx_frame_done <= 1'b0;
            rx_fifo_read  <= 1'b1;
            @(posedge pclk);
            check({31'h0, rx_overwrite}, {31'h0, c == 8});
            @(posedge pclk);
            check({31'h0, rx_overwrite}, 32'h0);
            rd_chk(`SSIC_RAW_ADDR, raw_exp(c == 8, 0));
        end
        irq_chk(raw_exp(1, 0));
        apb(1'b1, `SSIC_CLEAR_ADDR, 32'h0);
        apb(1'b1, `SSIC_RAW_ADDR, 32'hF);
        apb(1'b1, `SSIC_MASKED_ADDR, 32'hF);
        rd_chk(`SSIC_RAW_ADDR, raw_exp(1, 0));
        apb(1'b1, `SSIC_CLEAR_ADDR, 32'h1);
        rd_chk(`SSIC_RAW_ADDR, raw_exp(0, 0));
        irq_chk(raw_exp(0, 0));
        $display("Test overrun done");
        // Odd divisor reads back even; bit time 2 x 2, timeout 128 cycles
        apb(1'b1, `SSIC_PRESCALE_ADDR, 32'h3);
        apb(1'b0, `SSIC_PRESCALE_ADDR, 32'h0);
        check(rd, 32'h2);
        apb(1'b1, `SSIC_RATE_ADDR, 32'h1);
        mask_m = 4'h2;
        apb(1'b1, `SSIC_MASK_ADDR, 32'h2);
        rx_count     <= 4'h1;
        rx_fifo_read <= 1'b0;
        repeat (96) @(posedge pclk);
        rd_chk(`SSIC_RAW_ADDR, raw_exp(0, 0));
        repeat (40) @(posedge pclk);
        rd_chk(`SSIC_RAW_ADDR, raw_exp(0, 1));
        irq_chk(raw_exp(0, 1));
        rx_count     <= 4'h0;
        rx_fifo_read <= 1'b1;
        rd_chk(`SSIC_MASKED_ADDR, 4'h2);
        apb(1'b1, `SSIC_CLEAR_ADDR, 32'h2);
        rd_chk(`SSIC_RAW_ADDR, raw_exp(0, 0));
        irq_chk(raw_exp(0, 0));
        $display("Test timeout done");
        // Mid-run reset drops the sticky bits, mask and divisor
        rx_count      <= 4'h8;
        rx_frame_done <= 1'b1;
        @(posedge pclk);
        rx_frame_done <= 1'b0;
        rx_count      <= 4'h0;
        tx_count      <= 4'h0;
        presetn       <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn       <= 1'b1;
        mask_m = 4'h0;
        rd_chk(`SSIC_RAW_ADDR, 4'h8);
        rd_chk(`SSIC_MASKED_ADDR, 4'h0);
        rd_chk(`SSIC_MASK_ADDR, 4'h0);
        apb(1'b0, `SSIC_PRESCALE_ADDR, 32'h0);
        check(rd, 32'h0);
        irq_chk(4'h8);
        $display("Test mid-run reset done");
        apb(1'b0, 32'h40040030, 32'h0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b0, `SSIC_CLEAR_ADDR, 32'h0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h0);
        $display("Test unmapped and write-only done");
        end_sim();
    end
endmodule // test_ssic_top
